/* pkg/chgo3_regs.svh */
// register offsets, field positions, reset values and timing counts for the option-3 register
`ifndef CHGO3_REGS_SVH
`define CHGO3_REGS_SVH

`define CHGO3_OFFSET_LO      8'h34
`define CHGO3_OFFSET_HI      8'h35
`define CHGO3_RESET          16'h0030
// upper byte fields (bit index within the 16-bit word)
`define CHGO3_HIZ_BIT        15
`define CHGO3_RESTORE_BIT    14
`define CHGO3_REMEASURE_BIT  13
`define CHGO3_REVSUP_BIT     12
`define CHGO3_OPTIM_BIT      11
// lower byte fields
`define CHGO3_CAUTIOUS_BIT   6
`define CHGO3_PIN_ROLE_BIT   5
// restore values for the neighbouring settings, millivolts
`define CHGO3_MINSYS_1S_MV   16'h0E00
// floor measurement time, in ns, and its cycle count at 8 ns
`define CHGO3_MEAS_TIME_NS   32'h0000_03E8
`define CHGO3_CLK_PERIOD_NS  32'h0000_0008
`define CHGO3_MEAS_CYCLES    (`CHGO3_MEAS_TIME_NS / `CHGO3_CLK_PERIOD_NS)

`endif

/* pkg/chgo3_pkg.sv */
// types shared by the option-3 register block
package chgo3_pkg;
   typedef enum logic [1:0] {
      CHGO3_RUN     = 2'b00,
      CHGO3_MEASURE = 2'b01,
      CHGO3_DONE    = 2'b10
   } chgo3_meas_t;
endpackage : chgo3_pkg

/* core/chgo3_sync.sv */
// two-flop synchroniser for the external control pin
`timescale 1ns/1ps
module chgo3_sync (
   input  wire logic CLK_SYS,
   input  wire logic SYS_RST,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   // first flop feeds only the second
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : chgo3_sync

/* core/chgo3_ctrl.sv */
// option-3 control register with mode outputs for a battery charge controller
//
// Overview of operation
// - hi-z request bit 15 puts device in minimal-current state, battery feeds system.
// - restore-defaults write returns registers to default, input floor kept.
// - on restore, minimum system voltage takes 3584 mV, charge voltage by cell pin.
// - restore-defaults bit clears itself after the reset completes.
// - re-measure bit 13 disables converter while input floor is measured.
// - measurement done clears re-measure bit and restarts converter.
// - reverse supply only when enable bit 12 set and external pin high.
// - bit 11 enables input current optimizer; zero at power-on.
// - bit 6 enables cautious peak-assist mode; zero at power-on.
// - pin role select chooses reverse supply (one) or peak assist (zero).
`timescale 1ns/1ps
`include "chgo3_regs.svh"
module chgo3_ctrl
   import chgo3_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   output logic             REG_ACK,
   input  wire logic        EXT_CTRL_PIN,
   input  wire logic        INPUT_ABOVE_UVLO,
   input  wire logic        FLOOR_MEAS_DONE,
   output logic             HIGH_IMPEDANCE_MODE,
   output logic             INTERNAL_REGULATOR_ON,
   output logic             SYSTEM_FROM_BATTERY,
   output logic             RESTORE_DEFAULTS,
   output logic      [15:0] MINIMUM_SYSTEM_VOLTAGE_MV,
   output logic             CHARGE_VOLTAGE_FROM_PIN,
   output logic             CONVERTER_ENABLE,
   output logic             FLOOR_MEASURE_START,
   output logic             REVERSE_SUPPLY_ACTIVE,
   output logic             INPUT_OPTIMIZER_ON,
   output logic             PEAK_ASSIST_ACTIVE,
   output logic             CAUTIOUS_PEAK_ASSIST_ON
);
   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [15:0] option_r;
   logic        restore_pend_r;
   chgo3_meas_t meas_r;
   logic [7:0]  meas_cnt_r;
   logic        pin_s;
   logic        wr_lo;
   logic        wr_hi;
   logic        meas_done;

   chgo3_sync u_pin_sync (
      .CLK_SYS (CLK_SYS),
      .SYS_RST (SYS_RST),
      .d       (EXT_CTRL_PIN),
      .q       (pin_s)
   );

   assign wr_lo = REG_WR && (REG_ADDR == `CHGO3_OFFSET_LO);
   assign wr_hi = REG_WR && (REG_ADDR == `CHGO3_OFFSET_HI);
   // done from the measuring unit, or a local timeout so the bit never sticks
   assign meas_done = (meas_r == CHGO3_MEASURE) &&
                      (FLOOR_MEAS_DONE || meas_cnt_r == 8'(`CHGO3_MEAS_CYCLES - 1));

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || restore_pend_r) begin
         // restore reloads this register too, clearing the command bit itself
         option_r <= `CHGO3_RESET;
      end else begin
         if (wr_lo) begin
            option_r[7:0] <= REG_WDATA;
         end
         if (wr_hi) begin
            option_r[15:8] <= REG_WDATA;
         end
         // completion wins unless a fresh write of the upper byte sets the re-measure bit
         if (meas_done && !(wr_hi && REG_WDATA[`CHGO3_REMEASURE_BIT-8])) begin
            option_r[`CHGO3_REMEASURE_BIT] <= 1'b0;
         end
      end
   end

   // one cycle to carry out the restore, then the bit reads back as zero
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         restore_pend_r <= 1'b0;
      end else begin
         restore_pend_r <= wr_hi && REG_WDATA[`CHGO3_RESTORE_BIT-8] && !restore_pend_r;
      end
   end

   // ------------------------------------------------------------
   // input floor measurement sequencer
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         meas_r     <= CHGO3_RUN;
         meas_cnt_r <= 8'h00;
      end else begin
         case (meas_r)
            CHGO3_RUN: begin
               meas_cnt_r <= 8'h00;
               if (option_r[`CHGO3_REMEASURE_BIT]) begin
                  meas_r <= CHGO3_MEASURE;
               end
            end
            CHGO3_MEASURE: begin
               meas_cnt_r <= meas_cnt_r + 8'h01;
               if (meas_done) begin
                  meas_r <= CHGO3_DONE;
               end
            end
            CHGO3_DONE: begin
               meas_r <= CHGO3_RUN;
            end
            default: begin
               meas_r <= CHGO3_RUN;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // mode outputs
   // ------------------------------------------------------------
   logic hiz;
   logic role_rev;
   assign hiz      = option_r[`CHGO3_HIZ_BIT];
   assign role_rev = option_r[`CHGO3_PIN_ROLE_BIT];

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         HIGH_IMPEDANCE_MODE   <= 1'b0;
         INTERNAL_REGULATOR_ON <= 1'b0;
         SYSTEM_FROM_BATTERY   <= 1'b0;
      end else begin
         HIGH_IMPEDANCE_MODE   <= hiz;
         INTERNAL_REGULATOR_ON <= INPUT_ABOVE_UVLO;
         SYSTEM_FROM_BATTERY   <= hiz;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         RESTORE_DEFAULTS          <= 1'b0;
         MINIMUM_SYSTEM_VOLTAGE_MV <= `CHGO3_MINSYS_1S_MV;
         CHARGE_VOLTAGE_FROM_PIN   <= 1'b0;
      end else begin
         RESTORE_DEFAULTS        <= restore_pend_r;
         CHARGE_VOLTAGE_FROM_PIN <= restore_pend_r;
         if (restore_pend_r) begin
            MINIMUM_SYSTEM_VOLTAGE_MV <= `CHGO3_MINSYS_1S_MV;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         CONVERTER_ENABLE    <= 1'b1;
         FLOOR_MEASURE_START <= 1'b0;
      end else begin
         // converter held off from the write until completion
         CONVERTER_ENABLE    <= !option_r[`CHGO3_REMEASURE_BIT] && meas_r != CHGO3_MEASURE;
         FLOOR_MEASURE_START <= meas_r == CHGO3_RUN && option_r[`CHGO3_REMEASURE_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         REVERSE_SUPPLY_ACTIVE   <= 1'b0;
         PEAK_ASSIST_ACTIVE      <= 1'b0;
         INPUT_OPTIMIZER_ON      <= 1'b0;
         CAUTIOUS_PEAK_ASSIST_ON <= 1'b0;
      end else begin
         REVERSE_SUPPLY_ACTIVE   <= option_r[`CHGO3_REVSUP_BIT] && pin_s && role_rev;
         PEAK_ASSIST_ACTIVE      <= pin_s && !role_rev;
         INPUT_OPTIMIZER_ON      <= option_r[`CHGO3_OPTIM_BIT];
         CAUTIOUS_PEAK_ASSIST_ON <= option_r[`CHGO3_CAUTIOUS_BIT];
      end
   end

   // ------------------------------------------------------------
   // read port: one-cycle answer, unmapped reads return zero
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00;
         REG_ACK   <= 1'b0;
      end else begin
         REG_ACK <= REG_RD || REG_WR;
         if (REG_RD) begin
            case (REG_ADDR)
               `CHGO3_OFFSET_LO: REG_RDATA <= option_r[7:0];
               `CHGO3_OFFSET_HI: REG_RDATA <= option_r[15:8];
               default:          REG_RDATA <= 8'h00;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_hiz_follows: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      hiz |=> HIGH_IMPEDANCE_MODE && SYSTEM_FROM_BATTERY)
      else $error("hi-z request not reflected");

   a_restore_clears: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (wr_hi && REG_WDATA[`CHGO3_RESTORE_BIT-8] && !restore_pend_r) |=>
         ##1 option_r == `CHGO3_RESET)
      else $error("restore did not reload register");

   a_restore_self_clear: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      restore_pend_r |=> !option_r[`CHGO3_RESTORE_BIT])
      else $error("restore bit did not self-clear");

   a_minsys_default: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      restore_pend_r |=> MINIMUM_SYSTEM_VOLTAGE_MV == `CHGO3_MINSYS_1S_MV &&
         CHARGE_VOLTAGE_FROM_PIN)
      else $error("minimum system voltage not restored");

   a_conv_off_meas: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (meas_r == CHGO3_MEASURE) |=> !CONVERTER_ENABLE)
      else $error("converter running during floor measurement");

   a_meas_finish: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (meas_r == CHGO3_RUN && option_r[13] && !REG_WR) |-> ##[1:130] meas_r == CHGO3_DONE)
      else $error("floor measurement never completed");

   a_reverse_gate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      REVERSE_SUPPLY_ACTIVE |-> $past(option_r[12]) && $past(pin_s) && $past(role_rev))
      else $error("reverse supply without enable and pin");

   a_optimizer_follows: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(option_r[11]) |=> INPUT_OPTIMIZER_ON)
      else $error("optimizer enable not applied");

   a_cautious_clears: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $fell(option_r[6]) |=> !CAUTIOUS_PEAK_ASSIST_ON)
      else $error("cautious peak assist not cleared");

   a_role_peak: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      PEAK_ASSIST_ACTIVE |-> !REVERSE_SUPPLY_ACTIVE)
      else $error("pin drives both modes");
endmodule : chgo3_ctrl

/* verif/chgo3_host.sv */
// host model that reaches the option-3 register over the byte bus
`timescale 1ns/1ps
module chgo3_host (
   input  wire logic       CLK_SYS,
   output logic      [7:0] REG_ADDR,
   output logic            REG_WR,
   output logic            REG_RD,
   output logic      [7:0] REG_WDATA,
   input  wire logic [7:0] REG_RDATA,
   input  wire logic       REG_ACK
);
   initial begin
      REG_ADDR = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_WDATA = 8'h00;
   end
   // ----
   // one-cycle strobe per byte
   // ----
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w,
                       output logic [8:0] ans);
      @(negedge CLK_SYS);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = w;
      REG_RD = !w;
      @(negedge CLK_SYS);
      ans = {REG_ACK, REG_RDATA};
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      // released lines show junk, not the last value
      REG_ADDR = ~a;
      REG_WDATA = ~d;
   endtask : xfer
endmodule : chgo3_host

/* verif/testbench.sv */
// self-checking bench for the option-3 control register
`timescale 1ns/1ps
`include "chgo3_regs.svh"
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        pin = 1'b0;
   logic        uvlo = 1'b1;
   logic        done = 1'b0;
   logic [7:0]  addr, wdata, rdata;
   logic        wr, rd, ack;
   logic [15:0] minsys;
   logic        hiz, regon, frombat, restore, cvpin, conv, mstart, rev, optim, peak, caut;
   logic [8:0]  ans;
   int          err_count = 0;
   int          compares = 0;

   always #4 clk = ~clk;

   chgo3_host host (.CLK_SYS(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack));

   chgo3_ctrl dut (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack),
      .EXT_CTRL_PIN(pin), .INPUT_ABOVE_UVLO(uvlo), .FLOOR_MEAS_DONE(done),
      .HIGH_IMPEDANCE_MODE(hiz), .INTERNAL_REGULATOR_ON(regon),
      .SYSTEM_FROM_BATTERY(frombat), .RESTORE_DEFAULTS(restore),
      .MINIMUM_SYSTEM_VOLTAGE_MV(minsys), .CHARGE_VOLTAGE_FROM_PIN(cvpin),
      .CONVERTER_ENABLE(conv), .FLOOR_MEASURE_START(mstart),
      .REVERSE_SUPPLY_ACTIVE(rev), .INPUT_OPTIMIZER_ON(optim),
      .PEAK_ASSIST_ACTIVE(peak), .CAUTIOUS_PEAK_ASSIST_ON(caut));

   // ----
   // helpers
   // ----
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      host.xfer(a, d, 1'b1, ans);
      chk(16'(ans[8]), 16'h0001);
   endtask : wr8
   task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
      host.xfer(a, 8'h00, 1'b0, ans);
      chk(16'(ans), {7'h00, 1'b1, exp});
   endtask : rd8
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // ----
   // scenarios
   // ----
   task automatic t_reset;
      rd8(8'h34, 8'(`CHGO3_RESET));
      rd8(8'h35, 8'h00);
      rd8(8'h36, 8'h00);
      chk(16'({conv, optim, caut}), 16'h0004);
   endtask : t_reset
   task automatic t_fields;
      wr8(8'h35, 8'h0F);
      wr8(8'h34, 8'hF0);
      cyc(2);
      rd8(8'h35, 8'h0F);
      rd8(8'h34, 8'hF0);
      chk(16'({optim, caut, hiz, rev}), 16'h000C);
      wr8(8'h35, 8'h00);
      wr8(8'h34, 8'h30);
      cyc(2);
      chk(16'({optim, caut}), 16'h0000);
   endtask : t_fields
   task automatic t_hiz;
      wr8(8'h35, 8'h80);
      cyc(2);
      chk(16'({hiz, frombat, regon}), 16'h0007);
      uvlo = 1'b0;
      cyc(2);
      chk(16'({hiz, regon}), 16'h0002);
      uvlo = 1'b1;
      wr8(8'h35, 8'h00);
      cyc(2);
      chk(16'({hiz, frombat}), 16'h0000);
   endtask : t_hiz
   task automatic t_revsup;
      pin = 1'b1;
      cyc(4);
      chk(16'({rev, peak}), 16'h0000);
      wr8(8'h35, 8'h10);
      cyc(2);
      chk(16'({rev, peak}), 16'h0002);
      pin = 1'b0;
      cyc(4);
      chk(16'({rev, peak}), 16'h0000);
      pin = 1'b1;
      wr8(8'h34, 8'h10);
      cyc(4);
      chk(16'({rev, peak}), 16'h0001);
      pin = 1'b0;
      wr8(8'h35, 8'h00);
      wr8(8'h34, 8'h30);
   endtask : t_revsup
   task automatic t_measure;
      wr8(8'h35, 8'h20);
      cyc(1);
      chk(16'({conv, mstart}), 16'h0001);
      cyc(10);
      chk(16'(conv), 16'h0000);
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      cyc(3);
      chk(16'(conv), 16'h0001);
      rd8(8'h35, 8'h00);
      // no done from the measuring unit: only the local timeout may end it
      wr8(8'h35, 8'h20);
      cyc(int'(`CHGO3_MEAS_CYCLES) - 5);
      chk(16'(conv), 16'h0000);
      cyc(10);
      chk(16'(conv), 16'h0001);
      rd8(8'h35, 8'h00);
   endtask : t_measure
   task automatic t_restore;
      wr8(8'h35, 8'h18);
      wr8(8'h34, 8'h50);
      wr8(8'h35, 8'h58);
      cyc(1);
      chk(16'({restore, cvpin}), 16'h0003);
      rd8(8'h35, 8'h00);
      rd8(8'h34, 8'h30);
      chk(16'({optim, caut, rev}), 16'h0000);
      chk(minsys, `CHGO3_MINSYS_1S_MV);
   endtask : t_restore

   task automatic report_and_stop;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      cyc(3);
      rst = 1'b0;
      t_reset;
      t_fields;
      t_hiz;
      t_revsup;
      t_measure;
      t_restore;
      report_and_stop;
   end
   // the full sequence needs well under 300 cycles
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
endmodule : testbench
